// ===== design/bdstat_pkg.sv
// Constants for the buffer descriptor status block
`default_nettype none
package bdstat_pkg;
   // ****************************************
   // Register map (word index times four)
   // ****************************************
   localparam logic [9:0] ADDR_DESC_BASE = 10'h000;
   localparam logic [9:0] ADDR_LAST_STAT = 10'h100;
   localparam logic [9:0] ADDR_EP_STALL = 10'h104;
   localparam logic [9:0] ADDR_IRQ_STAT = 10'h108;
   localparam logic [9:0] ADDR_IRQ_CLR = 10'h10c;
   localparam logic [9:0] ADDR_IRQ_EN = 10'h110;
   // ****************************************
   // Descriptor status word fields
   // ****************************************
   localparam int OWN_BIT = 15;
   localparam int TOG_BIT = 14;
   localparam int SYNC_BIT = 11;
   localparam int STALL_BIT = 10;
   localparam int BC_W = 10;
   localparam logic [15:0] DESC_WMASK = 16'hcfff;
   // ****************************************
   // Last transfer status fields
   // ****************************************
   localparam int EP_LSB = 4;
   localparam int DIR_BIT = 3;
   localparam int PP_BIT = 2;
   // ****************************************
   // Interrupt status bits
   // ****************************************
   localparam int IRQ_DONE = 0;
   localparam int IRQ_STALL = 1;
   localparam int IRQ_DROP = 2;
   localparam int IRQ_W = 3;
   // ****************************************
   // Engine outcomes
   // ****************************************
   typedef enum logic [3:0] {
      RES_IGNORE = 4'b0001,
      RES_STALL = 4'b0010,
      RES_DROP = 4'b0100,
      RES_DONE = 4'b1000
   } result_type;
endpackage
`default_nettype wire

// ===== design/desc_ram.sv
// Descriptor status word storage, registered read, two ports
`default_nettype none
module desc_ram #(
   parameter int DEPTH = 64,
   parameter int AW = 6,
   parameter int DW = 16
) (
   // Clock
   input wire logic clock,
   // Port A
   input wire logic a_we,
   input wire logic [AW-1:0] a_addr,
   input wire logic [DW-1:0] a_wdata,
   output logic [DW-1:0] a_rdata,
   // Port B
   input wire logic b_we,
   input wire logic [AW-1:0] b_addr,
   input wire logic [DW-1:0] b_wdata,
   output logic [DW-1:0] b_rdata
);
   // Contents unknown after reset, as for the real table
   logic [DW-1:0] mem_ff [DEPTH];
   always_ff @(posedge clock) begin
      if (a_we) begin
         mem_ff[a_addr] <= a_wdata;
      end
      if (b_we) begin
         mem_ff[b_addr] <= b_wdata;
      end
      a_rdata <= mem_ff[a_addr];
      b_rdata <= mem_ff[b_addr];
   end
endmodule
`default_nettype wire

// ===== design/usb_buffer_descriptor_status.sv
// Descriptor status handling and last transfer status reporting
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`default_nettype none
module usb_buffer_descriptor_status
   import bdstat_pkg::*;
#(
   parameter int NUM_DESC = 64,
   parameter int NUM_EP = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Engine transaction request
   input wire logic txn_valid,
   input wire logic [3:0] txn_endpoint,
   input wire logic txn_dir_tx,
   input wire logic txn_odd_bank,
   input wire logic txn_data1,
   input wire logic [9:0] txn_count,
   // Engine transaction answer
   output logic txn_done,
   output logic [3:0] txn_result,
   output logic txn_toggle,
   output logic [9:0] txn_limit,
   // Endpoint stall flags and interrupt
   output logic [15:0] endpoint_stall_flag,
   output logic irq
);
   // ****************************************
   // Descriptor index and memory
   // ****************************************
   // Index: endpoint, direction, bank, giving 64 entries
   logic [5:0] eng_idx;
   assign eng_idx = {txn_endpoint, txn_dir_tx, txn_odd_bank};
   logic bus_we;
   logic eng_we;
   logic [15:0] bus_wdata;
   logic [15:0] eng_wdata;
   logic [15:0] bus_rdata;
   logic [15:0] eng_rdata;
   logic [5:0] eidx_ff;
   desc_ram #(.DEPTH(NUM_DESC), .AW(6), .DW(16)) u_ram (
      .clock(clock),
      .a_we(bus_we),
      .a_addr(address[7:2]),
      .a_wdata(bus_wdata),
      .a_rdata(bus_rdata),
      .b_we(eng_we),
      .b_addr(eidx_ff),
      .b_wdata(eng_wdata),
      .b_rdata(eng_rdata)
   );
   // ****************************************
   // Engine sequencer
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_EVAL = 4'b0100,
      ST_RESP = 4'b1000
   } eng_state_type;
   eng_state_type state_ff;
   logic [3:0] ep_ff;
   logic dir_ff;
   logic odd_ff;
   logic data1_ff;
   logic [9:0] cnt_ff;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               if (txn_valid) begin
                  state_ff <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               state_ff <= ST_EVAL;
            end
            ST_EVAL: begin
               state_ff <= ST_RESP;
            end
            ST_RESP: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         eidx_ff <= 6'h0;
         ep_ff <= 4'h0;
         dir_ff <= 1'b0;
         odd_ff <= 1'b0;
         data1_ff <= 1'b0;
         cnt_ff <= 10'h000;
      end else if (state_ff == ST_IDLE && txn_valid) begin
         eidx_ff <= eng_idx;
         ep_ff <= txn_endpoint;
         dir_ff <= txn_dir_tx;
         odd_ff <= txn_odd_bank;
         data1_ff <= txn_data1;
         cnt_ff <= txn_count;
      end
   end
   // Eval cycle decides the outcome from the fetched word
   result_type nxt_result;
   logic sync_bad;
   always_comb begin
      // Toggle compared only on receive with sync on
      sync_bad = !dir_ff && eng_rdata[SYNC_BIT] && (eng_rdata[TOG_BIT] != data1_ff);
      if (!eng_rdata[OWN_BIT]) begin
         nxt_result = RES_IGNORE;
      end else if (eng_rdata[STALL_BIT]) begin
         nxt_result = RES_STALL;
      end else if (sync_bad) begin
         nxt_result = RES_DROP;
      end else begin
         nxt_result = RES_DONE;
      end
   end
   // Completion writes actual count and hands word back to core
   assign eng_we = (state_ff == ST_EVAL) && (nxt_result == RES_DONE);
   assign eng_wdata = {1'b0, eng_rdata[14:10], cnt_ff};
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         txn_done <= 1'b0;
         txn_result <= 4'h0;
         txn_toggle <= 1'b0;
         txn_limit <= 10'h000;
      end else begin
         txn_done <= (state_ff == ST_EVAL);
         if (state_ff == ST_EVAL) begin
            txn_result <= nxt_result;
            txn_toggle <= eng_rdata[TOG_BIT];
            txn_limit <= eng_rdata[BC_W-1:0];
         end
      end
   end
   // ****************************************
   // Last transfer status
   // ****************************************
   logic [7:0] last_stat_ff;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         last_stat_ff <= 8'h00;
      end else if (eng_we) begin
         // Same edge as the descriptor write
         last_stat_ff <= {ep_ff, dir_ff, odd_ff, 2'b00};
      end
   end
   // ****************************************
   // Endpoint stall flags
   // ****************************************
   logic stall_evt;
   assign stall_evt = (state_ff == ST_EVAL) && (nxt_result == RES_STALL);
   logic bus_wr;
   logic bus_rd;
   logic wr_req;
   // Writes land on the edge that sees waitrequest low, never earlier
   assign bus_wr = write && !waitrequest;
   assign bus_rd = read && waitrequest;
   assign wr_req = write && waitrequest;
   logic stall_wr;
   assign stall_wr = bus_wr && (address == ADDR_EP_STALL) && (byteenable[1:0] == 2'b11);
   generate
      for (genvar i = 0; i < NUM_EP; i++) begin : g_stall
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               endpoint_stall_flag[i] <= 1'b0;
            end else if (stall_evt && ep_ff == 4'(i)) begin
               // Set beats a same-cycle software clear
               endpoint_stall_flag[i] <= 1'b1;
            end else if (stall_wr && writedata[i]) begin
               endpoint_stall_flag[i] <= 1'b0;
            end
         end
      end
   endgenerate
   // ****************************************
   // Interrupts
   // ****************************************
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_en_ff;
   logic [IRQ_W-1:0] evt;
   assign evt = {state_ff == ST_EVAL && nxt_result == RES_DROP, stall_evt, eng_we};
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_stat_ff <= '0;
      end else if (bus_wr && address == ADDR_IRQ_CLR && byteenable[0]) begin
         irq_stat_ff <= (irq_stat_ff & ~writedata[IRQ_W-1:0]) | evt;
      end else begin
         irq_stat_ff <= irq_stat_ff | evt;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_en_ff <= '0;
      end else if (bus_wr && address == ADDR_IRQ_EN && byteenable[0]) begin
         irq_en_ff <= writedata[IRQ_W-1:0];
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_ff & irq_en_ff);
      end
   end
   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // Descriptor writes mask reserved bits, so they stay zero
   logic desc_hit;
   assign desc_hit = (address[9:8] == ADDR_DESC_BASE[9:8]);
   assign bus_we = bus_wr && desc_hit && (byteenable[1:0] == 2'b11);
   assign bus_wdata = writedata[15:0] & DESC_WMASK;
   // Reads take three cycles, two with waitrequest high, so the memory word is registered
   logic rd_wait_ff;
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= bus_rd && !rd_wait_ff;
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
      end else if (!waitrequest) begin
         waitrequest <= 1'b1;
      end else if (wr_req || (bus_rd && rd_wait_ff)) begin
         waitrequest <= 1'b0;
      end
   end
   logic [31:0] nxt_readdata;
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      if (desc_hit) begin
         nxt_readdata = {16'h0000, bus_rdata};
      end else begin
         unique case (address)
            ADDR_LAST_STAT: nxt_readdata = {24'h00_0000, last_stat_ff};
            ADDR_EP_STALL: nxt_readdata = {16'h0000, endpoint_stall_flag};
            ADDR_IRQ_STAT: nxt_readdata = {29'h0, irq_stat_ff};
            ADDR_IRQ_EN: nxt_readdata = {29'h0, irq_en_ff};
            default: nxt_readdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         readdata <= 32'h0000_0000;
      end else if (bus_rd && rd_wait_ff) begin
         readdata <= nxt_readdata;
      end
   end
   // ****************************************
   // Checks
   // ****************************************
   a_stall_sets_flag: assert property (@(posedge clock) disable iff (sys_rst)
      stall_evt |=> endpoint_stall_flag[ep_ff])
      else $error("stall did not set endpoint flag");
   a_unowned_no_write: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && !eng_rdata[OWN_BIT]) |-> !eng_we)
      else $error("unowned descriptor was written");
   a_stall_no_write: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && eng_rdata[OWN_BIT] && eng_rdata[STALL_BIT]) |-> !eng_we ##1 txn_result == RES_STALL)
      else $error("stalled descriptor modified");
   a_count_written: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |-> eng_wdata[9:0] == cnt_ff)
      else $error("byte count not updated");
   a_status_fields: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |=> last_stat_ff == {$past(ep_ff), $past(dir_ff), $past(odd_ff), 2'b00})
      else $error("status fields not updated together");
   a_sync_drop: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && eng_rdata[OWN_BIT] && !eng_rdata[STALL_BIT] && sync_bad) |=> txn_result == RES_DROP)
      else $error("bad toggle not dropped");
   a_nosync_pass: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && eng_rdata[OWN_BIT] && !eng_rdata[STALL_BIT] && !eng_rdata[SYNC_BIT]) |-> eng_we)
      else $error("toggle checked without sync enable");
   a_done_timing: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_IDLE && txn_valid) |-> ##3 txn_done)
      else $error("answer not three cycles after request");
   // ****************************************
   // Field and event checks
   // ****************************************
   a_toggle_report: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL) |=> txn_toggle == $past(eng_rdata[TOG_BIT]))
      else $error("toggle bit not reported");
   a_limit_report: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL) |=> txn_limit == $past(eng_rdata[BC_W-1:0]))
      else $error("byte count limit not reported");
   a_done_word: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |-> (eng_wdata[TOG_BIT:STALL_BIT] == eng_rdata[TOG_BIT:STALL_BIT]) && !eng_wdata[OWN_BIT])
      else $error("completed word lost its fields");
   a_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
      bus_we |-> (bus_wdata & ~DESC_WMASK) == 16'h0000)
      else $error("reserved descriptor bits written");
   a_stall_irq: assert property (@(posedge clock) disable iff (sys_rst)
      stall_evt |=> irq_stat_ff[IRQ_STALL])
      else $error("stall event not recorded");
   a_flag_from_stall: assert property (@(posedge clock) disable iff (sys_rst)
      (endpoint_stall_flag & ~$past(endpoint_stall_flag)) != 16'h0000 |-> $past(stall_evt))
      else $error("stall flag rose without a stall");
   a_drop_no_write: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && nxt_result == RES_DROP) |-> !eng_we)
      else $error("dropped packet wrote descriptor");
   a_drop_irq: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && nxt_result == RES_DROP) |=> irq_stat_ff[IRQ_DROP])
      else $error("drop event not recorded");
   a_ignore_answer: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && !eng_rdata[OWN_BIT]) |=> txn_result == RES_IGNORE)
      else $error("unowned descriptor not ignored");
   a_stat_held: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff == ST_EVAL && nxt_result != RES_DONE) |=> last_stat_ff == $past(last_stat_ff))
      else $error("status moved without descriptor update");
   a_busy_no_take: assert property (@(posedge clock) disable iff (sys_rst)
      (state_ff != ST_IDLE) |=> eidx_ff == $past(eidx_ff))
      else $error("request taken while busy");
   a_ep_field: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |=> last_stat_ff[EP_LSB+:4] == $past(ep_ff))
      else $error("endpoint field wrong");
   a_dir_field: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |=> last_stat_ff[DIR_BIT] == $past(dir_ff))
      else $error("direction field wrong");
   a_bank_field: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |=> last_stat_ff[PP_BIT] == $past(odd_ff))
      else $error("bank field wrong");
   a_done_irq: assert property (@(posedge clock) disable iff (sys_rst)
      eng_we |=> irq_stat_ff[IRQ_DONE])
      else $error("completion not recorded");
   a_done_pulse: assert property (@(posedge clock) disable iff (sys_rst)
      txn_done |=> !txn_done)
      else $error("answer longer than one cycle");
   a_wait_pulse: assert property (@(posedge clock) disable iff (sys_rst)
      !waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
endmodule
`default_nettype wire

// ===== verif/usb_engine_model.sv
// Engine-side partner that issues transaction requests to the block
`default_nettype none
module usb_engine_model (
   // Clock
   input wire logic clock,
   // Transaction request
   output logic txn_valid,
   output logic [3:0] txn_endpoint,
   output logic txn_dir_tx,
   output logic txn_odd_bank,
   output logic txn_data1,
   output logic [9:0] txn_count,
   // Transaction answer
   input wire logic txn_done
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      txn_valid = 1'b0;
      txn_endpoint = 4'h0;
      txn_dir_tx = 1'b0;
      txn_odd_bank = 1'b0;
      txn_data1 = 1'b0;
      txn_count = 10'h000;
   end
   // *****
   // One request, then wait for the answer
   // *****
   task automatic send(input logic [3:0] ep, input logic dir, input logic odd, input logic d1,
                       input logic [9:0] cnt);
      int n;
      @(posedge clock);
      txn_valid <= 1'b1;
      txn_endpoint <= ep;
      txn_dir_tx <= dir;
      txn_odd_bank <= odd;
      txn_data1 <= d1;
      txn_count <= cnt;
      @(posedge clock);
      txn_valid <= 1'b0;
      // Released fields inverted so a stale value is never mistaken for valid
      txn_endpoint <= ~ep;
      txn_dir_tx <= ~dir;
      txn_odd_bank <= ~odd;
      txn_data1 <= ~d1;
      txn_count <= ~cnt;
      n = 0;
      while (txn_done !== 1'b1 && n < 8) begin
         @(posedge clock);
         n++;
      end
   endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the descriptor status block
`default_nettype none
module tb_top import bdstat_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] address = 10'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] readdata;
   logic waitrequest, txn_valid, txn_dir_tx, txn_odd_bank, txn_data1, txn_done, txn_toggle, irq;
   logic [3:0] txn_endpoint, txn_result;
   logic [9:0] txn_count, txn_limit;
   logic [15:0] endpoint_stall_flag;
   logic [15:0] dm [64];
   logic [15:0] sm = 16'h0000;
   logic [2:0] im = 3'h0;
   logic [31:0] v, w;
   logic [15:0] d;
   logic [5:0] idx;
   logic [7:0] ls;
   result_type r;
   int seed = 94900;
   int mismatches = 0;
   int check_count = 0;
   always #50 clock = ~clock;
   usb_buffer_descriptor_status u_usb_buffer_descriptor_status (.clock(clock), .sys_rst(sys_rst),
      .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .txn_valid(txn_valid), .txn_endpoint(txn_endpoint),
      .txn_dir_tx(txn_dir_tx), .txn_odd_bank(txn_odd_bank), .txn_data1(txn_data1), .txn_count(txn_count),
      .txn_done(txn_done), .txn_result(txn_result), .txn_toggle(txn_toggle), .txn_limit(txn_limit),
      .endpoint_stall_flag(endpoint_stall_flag), .irq(irq));
   usb_engine_model u_usb_engine_model (.clock(clock), .txn_valid(txn_valid), .txn_endpoint(txn_endpoint),
      .txn_dir_tx(txn_dir_tx), .txn_odd_bank(txn_odd_bank), .txn_data1(txn_data1), .txn_count(txn_count),
      .txn_done(txn_done));
   // *****
   // Shared tasks
   // *****
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] dat, input logic [3:0] be);
      @(posedge clock);
      address <= a;
      writedata <= dat;
      byteenable <= be;
      write <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      @(posedge clock);
      address <= a;
      read <= 1'b1;
      do @(posedge clock); while (waitrequest !== 1'b0);
      read <= 1'b0;
      check(readdata, e);
   endtask
   // *****
   // Watchdog
   // *****
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      stop_test();
   end
   // *****
   // Main sequence
   // *****
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      check({waitrequest, irq, endpoint_stall_flag}, 32'h0002_0000);
      for (int i = 0; i < 64; i++) begin
         v = $random(seed);
         dm[i] = v[15:0] & 16'hcfff;
         wr(ADDR_DESC_BASE + 10'(i * 4), v, 4'hf);
      end
      for (int i = 0; i < 64; i++) begin
         rd_chk(ADDR_DESC_BASE + 10'(i * 4), {16'h0000, dm[i]});
      end
      // Partial lanes must not touch a descriptor
      wr(ADDR_DESC_BASE, 32'h0000_ffff, 4'hc);
      rd_chk(ADDR_DESC_BASE, {16'h0000, dm[0]});
      wr(10'h200, 32'hffff_ffff, 4'hf);
      rd_chk(10'h200, 32'h0000_0000);
      wr(ADDR_IRQ_EN, 32'h0000_0007, 4'hf);
      for (int t = 0; t < 80; t++) begin
         v = $random(seed);
         w = $random(seed);
         idx = v[5:0];
         dm[idx] = w[15:0] & 16'hcfff;
         wr(ADDR_DESC_BASE + {2'b00, idx, 2'b00}, w, 4'hf);
         u_usb_engine_model.send(idx[5:2], idx[1], idx[0], v[6], v[25:16]);
         check(txn_done, 1'b1);
         d = dm[idx];
         if (!d[15]) r = RES_IGNORE;
         else if (d[10]) r = RES_STALL;
         else if (d[11] && !idx[1] && v[6] != d[14]) r = RES_DROP;
         else r = RES_DONE;
         check(txn_result, r);
         if (d[15]) check({txn_toggle, txn_limit}, {d[14], d[9:0]});
         if (r == RES_STALL) begin
            sm[idx[5:2]] = 1'b1;
            im[IRQ_STALL] = 1'b1;
         end
         if (r == RES_DROP) im[IRQ_DROP] = 1'b1;
         if (r == RES_DONE) begin
            dm[idx] = {1'b0, d[14:10], v[25:16]};
            ls = {idx, 2'b00};
            im[IRQ_DONE] = 1'b1;
         end
         rd_chk(ADDR_DESC_BASE + {2'b00, idx, 2'b00}, {16'h0000, dm[idx]});
         if (r == RES_DONE) rd_chk(ADDR_LAST_STAT, {24'h0, ls});
         check(endpoint_stall_flag, sm);
      end
      rd_chk(ADDR_IRQ_STAT, im);
      check(irq, |im);
      rd_chk(ADDR_EP_STALL, sm);
      // Mask, then clear, then re-enable with nothing pending
      wr(ADDR_IRQ_EN, 32'h0000_0000, 4'hf);
      repeat (3) @(posedge clock);
      check(irq, 1'b0);
      wr(ADDR_IRQ_CLR, 32'h0000_0007, 4'hf);
      rd_chk(ADDR_IRQ_STAT, 32'h0000_0000);
      wr(ADDR_IRQ_EN, 32'h0000_0007, 4'hf);
      repeat (3) @(posedge clock);
      check(irq, 1'b0);
      wr(ADDR_EP_STALL, 32'h0000_ffff, 4'hf);
      rd_chk(ADDR_EP_STALL, 32'h0000_0000);
      check(endpoint_stall_flag, 16'h0000);
      stop_test();
   end
endmodule
`default_nettype wire
